/* rtl/bfd_top.sv */
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "bfd_consts.svh"
//
// Contract
// - mode selects three-pole or single-pole scheme
// - thresholds 0.001..30.000 pu, default 1.050
// - path delays 0..65.535 s in ms
// - two independent breaker failure elements
// - seal-in held only while current supervised
// - initiate direct or current supervised
// - re-trip immediately on initiation
// - three enabled timed paths declare failure
// - early path needs aux closed and current
// - main path ignores aux, needs current
// - path timeout enables high-set, then low-set
// - detectors evaluated only after path delay
// - slow path needs aux closed, in service
// - block input inhibits the whole scheme
// - zone trip held after declaration clears
// - status outputs for each path operation
// - target event and trip indicator on failure
// - current taken from one of six sources
// - separate low-set enable delay setting
// - separate trip hold period setting
module bfd_top #(
	parameter int TICK_CYCLES = `BFD_TICK_NS / `BFD_CLK_PERIOD_NS
) (
	// clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// avalon-mm slave
	input wire logic [6:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// measured currents per source, milli per unit
	input wire bfd_pkg::bfd_amps_t src_phase_i [`BFD_NUM_SRC],
	input wire bfd_pkg::bfd_amps_t src_neutral_i [`BFD_NUM_SRC],
	// element operands and outputs
	input wire bfd_pkg::bfd_in_t elem_in_i [2],
	output bfd_pkg::bfd_out_t elem_out_o [2]
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic over(input logic [15:0] amps, input logic [15:0] thr);
		over = amps >= thr;
	endfunction

	function automatic logic [15:0] fit(input logic [3:0] idx, input logic [15:0] val);
		logic [15:0] r;
		r = val;
		if (idx == `BFD_IDX_CTRL) begin
			if (val[`BFD_CTRL_SRC_MSB:`BFD_CTRL_SRC_LSB] > `BFD_SRC_MAX) begin
				r[`BFD_CTRL_SRC_MSB:`BFD_CTRL_SRC_LSB] = `BFD_SRC_MAX;
			end
			r[15:10] = 6'h00;
		end else if (idx <= `BFD_IDX_N_LO) begin
			if (val < `BFD_THR_MIN) begin
				r = `BFD_THR_MIN;
			end else if (val > `BFD_THR_MAX) begin
				r = `BFD_THR_MAX;
			end
		end
		fit = r;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [15:0] cfg_r [2][`BFD_NUM_CFG];
	bfd_pkg::bfd_bus_st_t bus_st_r;
	logic [31:0] rdata_r;
	logic [15:0] tick_cnt_r;
	logic tick_r;
	logic [15:0] tmr_r [2][4];
	logic [15:0] hold_r [2];
	logic seal_r [2];
	logic active_r [2];
	bfd_pkg::bfd_out_t out_r [2];

	logic inst_sel;
	logic [3:0] idx_sel;
	logic bus_req;
	logic stat_clr_led [2];

	assign inst_sel = avs_address_i[6];
	assign idx_sel = avs_address_i[5:2];
	assign bus_req = avs_read_i | avs_write_i;

	// ----------------------------------------
	// millisecond evaluation strobe
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (ce_i) begin
			if (tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
				tick_cnt_r <= 16'h0000;
				tick_r <= 1'b1;
			end else begin
				tick_cnt_r <= tick_cnt_r + 16'h0001;
				tick_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// per element combinational evaluation
	// ----------------------------------------
	logic blk [2];
	logic supv [2];
	logic hi_det [2];
	logic lo_det [2];
	logic init_ok [2];
	logic active [2];
	logic seal_nxt [2];
	logic tin [2][4];
	logic texp [2][4];
	logic cur_det [2];
	logic early_nxt [2];
	logic main_nxt [2];
	logic slow_nxt [2];
	logic fail_nxt [2];

	always_comb begin
		logic [15:0] ctl;
		logic three;
		logic [2:0] src;
		logic [15:0] ph;
		logic [15:0] nt;
		ctl = 16'h0000;
		three = 1'b0;
		src = 3'h0;
		ph = 16'h0000;
		nt = 16'h0000;
		for (int i = 0; i < 2; i++) begin
			ctl = cfg_r[i][`BFD_IDX_CTRL];
			three = ~ctl[`BFD_CTRL_SINGLE_POLE];
			src = ctl[`BFD_CTRL_SRC_MSB:`BFD_CTRL_SRC_LSB];
			ph = src_phase_i[src];
			nt = src_neutral_i[src];
			// neutral supervision only counts in the three-pole scheme
			supv[i] = over(ph, cfg_r[i][`BFD_IDX_PH_SUPV]) |
				(three & over(nt, cfg_r[i][`BFD_IDX_N_SUPV]));
			hi_det[i] = over(ph, cfg_r[i][`BFD_IDX_PH_HI]) |
				(three & over(nt, cfg_r[i][`BFD_IDX_N_HI]));
			lo_det[i] = over(ph, cfg_r[i][`BFD_IDX_PH_LO]) |
				(three & over(nt, cfg_r[i][`BFD_IDX_N_LO]));
			blk[i] = ~ctl[`BFD_CTRL_FUNC] | elem_in_i[i].scheme_block_in;
			init_ok[i] = elem_in_i[i].three_pole_initiate_in &
				(~ctl[`BFD_CTRL_AMP_SUPV] | supv[i]);
			seal_nxt[i] = ~blk[i] & ctl[`BFD_CTRL_SEAL] & supv[i] &
				(init_ok[i] | seal_r[i]);
			active[i] = ~blk[i] & (init_ok[i] | seal_r[i]);
			tin[i][0] = active[i] & ctl[`BFD_CTRL_EARLY] & elem_in_i[i].fast_aux_contact_in;
			tin[i][1] = active[i] & ctl[`BFD_CTRL_MAIN];
			tin[i][2] = active[i] & ctl[`BFD_CTRL_SLOW] &
				elem_in_i[i].normal_aux_contact_in & ~elem_in_i[i].out_of_service_in;
			for (int k = 0; k < 3; k++) begin
				texp[i][k] = tin[i][k] & (tmr_r[i][k] >= cfg_r[i][`BFD_IDX_DLY0 + k]);
			end
			tin[i][3] = texp[i][0] | texp[i][1];
			texp[i][3] = tin[i][3] & (tmr_r[i][3] >= cfg_r[i][`BFD_IDX_DLY0 + 3]);
			// detectors only matter once a path delay has run out
			cur_det[i] = tin[i][3] & (hi_det[i] | (texp[i][3] & lo_det[i]));
			early_nxt[i] = texp[i][0] & elem_in_i[i].fast_aux_contact_in & cur_det[i];
			main_nxt[i] = texp[i][1] & cur_det[i];
			slow_nxt[i] = texp[i][2];
			fail_nxt[i] = early_nxt[i] | main_nxt[i] | slow_nxt[i];
		end
	end

	// ----------------------------------------
	// path timers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 2; i++) begin
				for (int k = 0; k < 4; k++) begin
					tmr_r[i][k] <= 16'h0000;
				end
			end
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				for (int k = 0; k < 4; k++) begin
					if (!tin[i][k]) begin
						tmr_r[i][k] <= 16'h0000;
					end else if (tick_r && tmr_r[i][k] != 16'hFFFF) begin
						tmr_r[i][k] <= tmr_r[i][k] + 16'h0001;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// initiate, seal-in and outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 2; i++) begin
				seal_r[i] <= 1'b0;
				active_r[i] <= 1'b0;
				hold_r[i] <= 16'h0000;
				out_r[i] <= '0;
			end
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				seal_r[i] <= seal_nxt[i];
				active_r[i] <= active[i];
				out_r[i].retrip <= active[i];
				out_r[i].target <= 1'b0;
				if (blk[i]) begin
					out_r[i].early_op <= 1'b0;
					out_r[i].main_op <= 1'b0;
					out_r[i].slow_op <= 1'b0;
					out_r[i].fail <= 1'b0;
					out_r[i].zone_trip <= 1'b0;
					hold_r[i] <= 16'h0000;
				end else if (tick_r) begin
					out_r[i].early_op <= early_nxt[i];
					out_r[i].main_op <= main_nxt[i];
					out_r[i].slow_op <= slow_nxt[i];
					out_r[i].fail <= fail_nxt[i];
					out_r[i].zone_trip <= fail_nxt[i] | (hold_r[i] != 16'h0000);
					if (fail_nxt[i]) begin
						hold_r[i] <= cfg_r[i][`BFD_IDX_HOLD];
					end else if (hold_r[i] != 16'h0000) begin
						hold_r[i] <= hold_r[i] - 16'h0001;
					end
					out_r[i].target <= fail_nxt[i] & ~out_r[i].fail;
				end
				// new declaration wins over a software clear
				if (tick_r && !blk[i] && fail_nxt[i]) begin
					out_r[i].trip_led <= 1'b1;
				end else if (stat_clr_led[i]) begin
					out_r[i].trip_led <= 1'b0;
				end
			end
		end
	end

	assign elem_out_o = out_r;

	// ----------------------------------------
	// avalon-mm slave
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			stat_clr_led[i] = (bus_st_r == bfd_pkg::BFD_BUS_ACK) && avs_write_i &&
				(inst_sel == 1'(i)) && (idx_sel == `BFD_IDX_STATUS) &&
				avs_byteenable_i[0] && avs_writedata_i[`BFD_STAT_LED];
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus_st_r <= bfd_pkg::BFD_BUS_IDLE;
			rdata_r <= 32'h00000000;
		end else if (ce_i) begin
			case (bus_st_r)
				bfd_pkg::BFD_BUS_IDLE: begin
					if (bus_req) begin
						bus_st_r <= bfd_pkg::BFD_BUS_ACK;
						rdata_r <= 32'h00000000;
						if (avs_read_i && idx_sel < 4'(`BFD_NUM_CFG)) begin
							rdata_r <= {16'h0000, cfg_r[inst_sel][idx_sel]};
						end else if (avs_read_i && idx_sel == `BFD_IDX_STATUS) begin
							rdata_r <= {24'h000000, seal_r[inst_sel], out_r[inst_sel].trip_led,
								out_r[inst_sel].zone_trip, out_r[inst_sel].fail,
								out_r[inst_sel].slow_op, out_r[inst_sel].main_op,
								out_r[inst_sel].early_op, active_r[inst_sel]};
						end
					end
				end
				bfd_pkg::BFD_BUS_ACK: begin
					bus_st_r <= bfd_pkg::BFD_BUS_IDLE;
				end
				default: begin
					bus_st_r <= bfd_pkg::BFD_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 2; i++) begin
				cfg_r[i][`BFD_IDX_CTRL] <= `BFD_RST_CTRL;
				for (int k = 1; k <= 6; k++) begin
					cfg_r[i][k] <= `BFD_RST_THRESH;
				end
				for (int k = 7; k < `BFD_NUM_CFG; k++) begin
					cfg_r[i][k] <= `BFD_RST_DELAY;
				end
			end
		end else if (ce_i && bus_st_r == bfd_pkg::BFD_BUS_ACK && avs_write_i &&
				idx_sel < 4'(`BFD_NUM_CFG)) begin
			cfg_r[inst_sel][idx_sel] <= fit(idx_sel,
				merge(cfg_r[inst_sel][idx_sel], avs_writedata_i, avs_byteenable_i));
		end
	end

	assign avs_readdata_o = rdata_r;
	assign avs_waitrequest_o = bus_st_r[0];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_retrip_immed: assert property (
		ce_i && !blk[0] && init_ok[0] |=> out_r[0].retrip)
		else $error("re-trip missed on initiation");

	chk_block_clears: assert property (
		ce_i && blk[0] |=> !out_r[0].retrip && !out_r[0].zone_trip && !out_r[0].fail)
		else $error("blocked element still operates");

	chk_early_aux: assert property (
		$rose(out_r[0].early_op) |-> $past(elem_in_i[0].fast_aux_contact_in) && $past(tick_r))
		else $error("early path without closed aux");

	chk_slow_service: assert property (
		$rose(out_r[0].slow_op) |->
		$past(!elem_in_i[0].out_of_service_in && elem_in_i[0].normal_aux_contact_in))
		else $error("slow path while out of service");

	chk_fail_trips: assert property (
		out_r[0].fail |-> out_r[0].zone_trip && (!$rose(out_r[0].fail) || out_r[0].trip_led))
		else $error("failure without zone trip");

	chk_trip_hold: assert property (
		ce_i && tick_r && !blk[0] && !fail_nxt[0] && hold_r[0] != 16'h0000
		|=> out_r[0].zone_trip)
		else $error("zone trip dropped during hold");

	chk_target_pulse: assert property (
		out_r[0].target |-> out_r[0].fail ##1 (!out_r[0].target || !$past(ce_i)))
		else $error("target not a single pulse");

	chk_seal_release: assert property (
		ce_i && !supv[0] |=> !seal_r[0])
		else $error("seal-in held without current");

	chk_zero_delay: assert property (
		ce_i && tick_r && !blk[0] && tin[0][2] && cfg_r[0][`BFD_IDX_DLY0 + 2] == 16'h0000
		|=> out_r[0].slow_op)
		else $error("zero delay slow path late");

	chk_bus_answer: assert property (
		ce_i && bus_req && avs_waitrequest_o ##1 ce_i |-> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not one cycle");

endmodule

/* rtl/bfd_consts.svh */
`ifndef BFD_CONSTS_SVH
`define BFD_CONSTS_SVH

// ----------------------------------------
// register byte offsets inside one element, and the base of element two
// ----------------------------------------
`define BFD_OFS_CTRL 7'h00
`define BFD_OFS_PH_SUPV 7'h04
`define BFD_OFS_N_SUPV 7'h08
`define BFD_OFS_PH_HI 7'h0C
`define BFD_OFS_N_HI 7'h10
`define BFD_OFS_PH_LO 7'h14
`define BFD_OFS_N_LO 7'h18
`define BFD_OFS_DLY_EARLY 7'h1C
`define BFD_OFS_DLY_MAIN 7'h20
`define BFD_OFS_DLY_SLOW 7'h24
`define BFD_OFS_DLY_LOSET 7'h28
`define BFD_OFS_HOLD 7'h2C
`define BFD_OFS_STATUS 7'h30
`define BFD_OFS_ELEM2 7'h40

// ----------------------------------------
// register indices (offset / 4)
// ----------------------------------------
`define BFD_IDX_CTRL 4'h0
`define BFD_IDX_PH_SUPV 4'h1
`define BFD_IDX_N_SUPV 4'h2
`define BFD_IDX_PH_HI 4'h3
`define BFD_IDX_N_HI 4'h4
`define BFD_IDX_PH_LO 4'h5
`define BFD_IDX_N_LO 4'h6
`define BFD_IDX_DLY0 4'h7
`define BFD_IDX_HOLD 4'hB
`define BFD_IDX_STATUS 4'hC
`define BFD_NUM_CFG 12

// ----------------------------------------
// control and status field positions
// ----------------------------------------
`define BFD_CTRL_FUNC 0
`define BFD_CTRL_SINGLE_POLE 1
`define BFD_CTRL_SRC_LSB 2
`define BFD_CTRL_SRC_MSB 4
`define BFD_CTRL_AMP_SUPV 5
`define BFD_CTRL_SEAL 6
`define BFD_CTRL_EARLY 7
`define BFD_CTRL_MAIN 8
`define BFD_CTRL_SLOW 9
`define BFD_STAT_LED 7

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define BFD_RST_CTRL 16'h03E0
`define BFD_RST_THRESH 16'h041A
`define BFD_RST_DELAY 16'h0000
`define BFD_THR_MIN 16'h0001
`define BFD_THR_MAX 16'h7530
`define BFD_SRC_MAX 3'h5
`define BFD_NUM_SRC 6

// ----------------------------------------
// timing
// ----------------------------------------
`define BFD_CLK_PERIOD_NS 25
`define BFD_TICK_NS 1000000

`endif

/* rtl/bfd_pkg.sv */
package bfd_pkg;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef logic [15:0] bfd_amps_t;

	typedef struct packed {
		logic three_pole_initiate_in;
		logic scheme_block_in;
		logic fast_aux_contact_in;
		logic normal_aux_contact_in;
		logic out_of_service_in;
	} bfd_in_t;

	typedef struct packed {
		logic retrip;
		logic early_op;
		logic main_op;
		logic slow_op;
		logic fail;
		logic zone_trip;
		logic target;
		logic trip_led;
	} bfd_out_t;

	typedef enum logic [1:0] {
		BFD_BUS_IDLE = 2'b01,
		BFD_BUS_ACK = 2'b10
	} bfd_bus_st_t;

endpackage

/* bench/bfd_far_model.sv */
`timescale 1ns/100ps
`include "bfd_consts.svh"
// ----------------------------------------
// far side: trip logic, contacts, currents
// ----------------------------------------
module bfd_far_model (
	// commands from the bench
	input wire logic trip_cmd_i,
	input wire logic aux_closed_i,
	input wire logic out_srv_i,
	input wire logic block_i,
	input wire logic [15:0] amps_i,
	input wire logic [31:0] noise_i,
	// toward the device
	output bfd_pkg::bfd_in_t elem_o,
	output bfd_pkg::bfd_amps_t phase_o [`BFD_NUM_SRC],
	output bfd_pkg::bfd_amps_t neutral_o [`BFD_NUM_SRC]
);
	always_comb begin
		// only the protection trip command initiates
		elem_o.three_pole_initiate_in = trip_cmd_i;
		elem_o.scheme_block_in = block_i;
		elem_o.fast_aux_contact_in = aux_closed_i;
		elem_o.normal_aux_contact_in = aux_closed_i;
		elem_o.out_of_service_in = out_srv_i;
		// source 0 carries the fault, others carry noise
		for (int i = 0; i < `BFD_NUM_SRC; i++) begin
			phase_o[i] = (i == 0) ? amps_i : (noise_i[15:0] ^ 16'(i));
			neutral_o[i] = (i == 0) ? 16'h0000 : noise_i[31:16];
		end
	end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/100ps
`include "bfd_consts.svh"
module tb_top;
	localparam int TK = 8;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [6:0] adr = 7'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic wait_r;
	logic trip = 1'b0;
	logic aux = 1'b0;
	logic oos = 1'b0;
	logic blk = 1'b0;
	logic ce = 1'b1;
	logic [3:0] be = 4'hF;
	logic [15:0] amps = 16'h0000;
	logic [31:0] rnd = 32'h354C7FE6;
	bfd_pkg::bfd_in_t far_in;
	bfd_pkg::bfd_in_t elem_in [2];
	bfd_pkg::bfd_out_t eo [2];
	bfd_pkg::bfd_amps_t ph [`BFD_NUM_SRC];
	bfd_pkg::bfd_amps_t nt [`BFD_NUM_SRC];
	int err_total = 0;
	int n_tests = 0;
	logic [31:0] q [$];

	assign elem_in[0] = far_in;
	assign elem_in[1] = '0;

	initial begin
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	always @(posedge clk_sys_i) rnd <= lfsr(rnd);

	bfd_top #(.TICK_CYCLES(TK)) i_bfd_top (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(be),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_r),
		.src_phase_i(ph),
		.src_neutral_i(nt),
		.elem_in_i(elem_in),
		.elem_out_o(eo)
	);

	bfd_far_model i_bfd_far_model (
		.trip_cmd_i(trip),
		.aux_closed_i(aux),
		.out_srv_i(oos),
		.block_i(blk),
		.amps_i(amps),
		.noise_i(rnd),
		.elem_o(far_in),
		.phase_o(ph),
		.neutral_o(nt)
	);

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic end_of_test();
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// read data compared against the oldest note
	always @(posedge clk_sys_i) begin
		if (rd === 1'b1 && wait_r === 1'b0 && q.size() > 0) begin
			cmp("readdata", q.pop_front(), rdata);
		end
	end

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		if (!w) begin
			q.push_back(d);
		end
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wait_r !== 1'b0 && n < 50);
		cmp("waitrequest", 32'h0, 32'(wait_r));
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic wt(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (eo[0][b] !== v && n < lim) begin
			@(negedge clk_sys_i);
			n++;
		end
		cmp($sformatf("output bit %0d", b), 32'(v), 32'(eo[0][b]));
	endtask

	initial begin
		repeat (6000) @(posedge clk_sys_i);
		err_total++;
		end_of_test();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		for (int e = 0; e < 2; e++) begin
			for (int i = 0; i < 15; i++) begin
				bus(1'b0, {e[0], i[3:0], 2'b00}, (i == 0) ? 32'h3E0 : (i < 7) ? 32'h41A : 32'h0);
			end
		end
		bus(1'b1, 7'h04, 32'h0);
		bus(1'b0, 7'h04, 32'h1);
		bus(1'b1, 7'h04, 32'hFFFF);
		bus(1'b0, 7'h04, 32'h7530);
		// only the upper byte lane is written
		be <= 4'h2;
		bus(1'b1, 7'h04, 32'h12AB);
		be <= 4'hF;
		bus(1'b0, 7'h04, 32'h1230);
		bus(1'b1, 7'h00, 32'h3FF);
		bus(1'b0, 7'h00, 32'h3F7);
		bus(1'b1, 7'h20, 32'hFFFF);
		bus(1'b0, 7'h20, 32'hFFFF);
		bus(1'b1, 7'h34, 32'h5);
		bus(1'b0, 7'h34, 32'h0);
		bus(1'b0, 7'h40, 32'h3E0);
		bus(1'b1, 7'h04, 32'h41A);
		bus(1'b1, 7'h20, 32'h0);
		bus(1'b1, 7'h2C, 32'h3);
		bus(1'b1, 7'h00, 32'h121);
		// supervised initiate below and at the pickup
		amps <= 16'd1049;
		trip <= 1'b1;
		repeat (4) @(negedge clk_sys_i);
		cmp("retrip low current", 32'h0, 32'(eo[0][7]));
		@(posedge clk_sys_i);
		amps <= 16'd1050;
		@(posedge clk_sys_i);
		@(negedge clk_sys_i);
		cmp("retrip", 32'h1, 32'(eo[0][7]));
		wt(3, 1'b1, TK + 2);
		cmp("main op", 32'h1, 32'(eo[0][5]));
		cmp("target", 32'h1, 32'(eo[0][1]));
		cmp("zone trip", 32'h1, 32'(eo[0][2]));
		cmp("early op", 32'h0, 32'(eo[0][6]));
		cmp("element two", 32'h0, 32'(eo[1]));
		@(negedge clk_sys_i);
		cmp("target pulse", 32'h0, 32'(eo[0][1]));
		@(posedge clk_sys_i);
		amps <= 16'h0000;
		trip <= 1'b0;
		wt(3, 1'b0, 2 * TK);
		repeat (2 * TK) @(negedge clk_sys_i);
		cmp("zone hold", 32'h1, 32'(eo[0][2]));
		wt(2, 1'b0, 2 * TK);
		cmp("trip led", 32'h1, 32'(eo[0][0]));
		bus(1'b1, 7'h30, 32'h80);
		bus(1'b0, 7'h30, 32'h0);
		cmp("led cleared", 32'h0, 32'(eo[0][0]));
		// block input inhibits
		blk <= 1'b1;
		trip <= 1'b1;
		amps <= 16'd2000;
		repeat (3 * TK) @(negedge clk_sys_i);
		cmp("blocked", 32'h0, 32'(eo[0]));
		@(posedge clk_sys_i);
		blk <= 1'b0;
		trip <= 1'b0;
		// early path needs closed aux contact
		bus(1'b1, 7'h1C, 32'h2);
		bus(1'b1, 7'h00, 32'h81);
		trip <= 1'b1;
		repeat (5 * TK) @(negedge clk_sys_i);
		cmp("early aux open", 32'h0, 32'(eo[0][6]));
		@(posedge clk_sys_i);
		aux <= 1'b1;
		wt(6, 1'b1, 4 * TK);
		@(posedge clk_sys_i);
		trip <= 1'b0;
		amps <= 16'h0000;
		// slow path needs in service, no current
		bus(1'b1, 7'h24, 32'h0);
		bus(1'b1, 7'h00, 32'h201);
		oos <= 1'b1;
		trip <= 1'b1;
		repeat (4 * TK) @(negedge clk_sys_i);
		cmp("slow out of service", 32'h0, 32'(eo[0][4]));
		@(posedge clk_sys_i);
		oos <= 1'b0;
		ce <= 1'b0;
		repeat (3 * TK) @(negedge clk_sys_i);
		cmp("frozen by enable", 32'h0, 32'(eo[0][4]));
		@(posedge clk_sys_i);
		ce <= 1'b1;
		wt(4, 1'b1, 3 * TK);
		@(posedge clk_sys_i);
		trip <= 1'b0;
		// seal-in holds the initiate while current flows
		bus(1'b1, 7'h20, 32'h64);
		bus(1'b1, 7'h00, 32'h141);
		amps <= 16'd2000;
		trip <= 1'b1;
		@(posedge clk_sys_i);
		trip <= 1'b0;
		repeat (4) @(negedge clk_sys_i);
		cmp("sealed retrip", 32'h1, 32'(eo[0][7]));
		@(posedge clk_sys_i);
		amps <= 16'h0000;
		repeat (3) @(negedge clk_sys_i);
		cmp("seal released", 32'h0, 32'(eo[0][7]));
		// low-set detector waits for its own delay
		bus(1'b1, 7'h0C, 32'hBB8);
		bus(1'b1, 7'h28, 32'h2);
		bus(1'b1, 7'h20, 32'h0);
		bus(1'b1, 7'h00, 32'h101);
		amps <= 16'd2000;
		trip <= 1'b1;
		repeat (TK + 2) @(negedge clk_sys_i);
		cmp("low-set too early", 32'h0, 32'(eo[0][5]));
		wt(5, 1'b1, 3 * TK);
		end_of_test();
	end
endmodule
